// [hw/core_status_regs.svh]
/*
 * Register addresses, field positions, reset values and fixed figures for the core
 * status registers and the interrupt entry logic.
 * Assumes an 8-bit special-register address space shared by all register pages.
 */
`ifndef CORE_STATUS_REGS_SVH
`define CORE_STATUS_REGS_SVH

// Special-register addresses
`define ADDR_STACK_POINTER   8'h81
`define ADDR_DATA_PTR_LOW    8'h82
`define ADDR_DATA_PTR_HIGH   8'h83
`define ADDR_STATUS_WORD     8'hd0
`define ADDR_PRIMARY_ARITH   8'he0
`define ADDR_SECOND_OPERAND  8'hf0
`define ADDR_IRQ_ENABLE0     8'ha8
`define ADDR_EXT_ENABLE1     8'he6
`define ADDR_EXT_ENABLE2     8'he7
`define ADDR_IRQ_LEVEL0      8'hb8
`define ADDR_IRQ_LEVEL1      8'hf6
`define ADDR_IRQ_LEVEL2      8'hf7
`define ADDR_IRQ_PENDING0    8'hc4
`define ADDR_IRQ_PENDING1    8'hc5
`define ADDR_IRQ_PENDING2    8'hc6

// Reset values
`define RESET_STACK_POINTER  8'h07
`define RESET_BYTE           8'h00

// Status word fields
`define PSW_CARRY            7
`define PSW_HALF_CARRY       6
`define PSW_BANK_HI          4
`define PSW_BANK_LO          3
`define PSW_SIGNED_WRAP      2
`define PSW_PARITY           0
`define PSW_WRITE_MASK       8'hfe
`define GLOBAL_IRQ_BIT       7

// Writable bits of the enable and pending registers
`define ENABLE0_MASK         8'hbf
`define ENABLE2_MASK         8'h3f
`define PENDING2_MASK        8'h0f

// Interrupt figures
`define NUM_SOURCES          20
`define VECTOR_BASE          16'h0003
`define VECTOR_SHIFT         3
`define RESERVED_SLOT        5'h13
`define HW_CLEAR_MASK        20'h0000f

`endif

// [hw/core_status_pkg.sv]
/*
 * Types shared by the status-register block and its test bench.
 * Assumes the register header is on the include path.
 */
package core_status_pkg;
	`include "core_status_regs.svh"

	// Arithmetic operations that touch the status flags
	typedef enum logic [2:0] {
		ARITH_ADD,
		ARITH_ADDC,
		ARITH_SUBB,
		ARITH_MUL,
		ARITH_DIV
	} arith_op_type;

	// Whole register state of the block
	typedef struct packed {
		logic [7:0]  stack_pointer;
		logic [7:0]  data_pointer_low;
		logic [7:0]  data_pointer_high;
		logic [7:0]  program_status_word;
		logic [7:0]  primary_arith_register;
		logic [7:0]  second_operand_register;
		logic [7:0]  irq_enable_reg0;
		logic [7:0]  ext_enable_reg1;
		logic [7:0]  ext_enable_reg2;
		logic [19:0] level;
		logic [19:0] pending;
		logic [19:0] req_delayed;
		logic        active_hi;
		logic        active_lo;
		logic [7:0]  read_data;
		logic        stack_write;
		logic        stack_read;
		logic [7:0]  stack_addr;
		logic [7:0]  stack_data;
		logic        vector_take;
		logic [15:0] vector_addr;
		logic [7:0]  bank_base;
		logic        parity;
	} state_type;
endpackage

// [hw/irq_pick_if.sv]
/*
 * Carrier between the status block and its request picker.
 * Assumes both ends run on the same clock; the picker is purely combinational.
 */
interface irq_pick_if;
	logic [19:0] req;
	logic        hit;
	logic [4:0]  index;

	modport pick (input req, output hit, output index);
	modport user (output req, input hit, input index);
endinterface

// [hw/irq_pick.sv]
/*
 * Fixed-order request picker: returns the lowest-numbered set request.
 * Assumes the caller has already masked requests by enable and level.
 */
module irq_pick (
	irq_pick_if.pick pick_port
);
	// Scan downward so the lowest index is the last to win
	always_comb begin
		pick_port.hit = 1'b0;
		pick_port.index = 5'h00;
		for (int i = 19; i >= 0; i--) begin
			if (pick_port.req[i]) begin
				pick_port.hit = 1'b1;
				pick_port.index = 5'(i);
			end
		end
	end
endmodule

// [hw/core_status_regs_and_irq_entry.sv]
/*
 * Core special registers (stack pointer, data pointer, accumulators, status word)
 * and the interrupt entry logic: pending flags, enables, two levels, vectoring.
 * Assumes the core pulses boundary_i at each instruction end and performs the
 * long call itself when vector_take_o rises; all inputs are on clk_i.
 */
// Functional notes
// - Stack pointer resets to 0x07, then reads and writes as a byte.
// - A push increments the stack pointer first, then stores at the new top.
// - Low and high data pointer bytes form a 16-bit address, both reset to zero.
// - Carry flag set on carry or borrow, cleared by other arithmetic.
// - Half carry set on nibble carry or borrow, cleared otherwise.
// - Status bits 5 and 1 are software flags never touched by hardware.
// - Bank choice bits 4..3 select register bank base 0x00, 0x08, 0x10, 0x18.
// - Add, add-with-carry, subtract set signed wrap on sign overflow.
// - Multiply sets signed wrap when the product exceeds 255.
// - Divide by zero sets signed wrap.
// - Those five instructions clear signed wrap when no overflow occurs.
// - Parity bit always equals odd parity of the accumulator, read only.
// - Twenty sources, each assignable to one of two levels.
// - Pending flags set on events regardless of any enable.
// - Enabled pending flag vectors after the current instruction completes.
// - Service routines end with return; execution resumes where it left off.
// - Per-source enables only count while the global enable is one.
// - Clearing global enable then a single-cycle instruction may still vector.
// - Only some pending flags clear on vectoring; software clears the rest.
// - Flag still set after return re-enters after exactly one more instruction.
// - Software writing one to a pending flag acts like a hardware event.
// Offsets, fields and fixed figures
`include "core_status_regs.svh"

module core_status_regs_and_irq_entry
	import core_status_pkg::*;
(
	input  logic         clk_i,
	input  logic         reset_i,
	input  logic [7:0]   sfr_addr_i,
	input  logic         sfr_write_i,
	input  logic         sfr_read_i,
	input  logic [7:0]   sfr_wdata_i,
	output logic [7:0]   sfr_rdata_o,
	input  logic         arith_valid_i,
	input  arith_op_type arith_op_i,
	input  logic [7:0]   arith_operand_i,
	input  logic         push_i,
	input  logic [7:0]   push_data_i,
	input  logic         pop_i,
	input  logic         data_ptr_inc_i,
	output logic         stack_write_o,
	output logic         stack_read_o,
	output logic [7:0]   stack_addr_o,
	output logic [7:0]   stack_data_o,
	output logic [15:0]  data_pointer16_o,
	output logic [7:0]   bank_base_o,
	output logic         parity_o,
	input  logic [19:0]  irq_event_i,
	input  logic         boundary_i,
	input  logic         multi_cycle_i,
	input  logic         return_from_irq_i,
	output logic         vector_take_o,
	output logic [15:0]  vector_addr_o,
	output logic         global_irq_enable_o
);
	// All registers live in st; next_st is the
	// value for the coming edge. One struct keeps
	// reset and the register process trivial.
	state_type   st;
	state_type   next_st;
	// Request path views, derived from st and multi_cycle_i
	logic [19:0] enable_vec;
	logic [19:0] live_req;
	logic [19:0] cand;
	logic [19:0] cand_hi;
	logic        global_on;

	// Pure logic; its choice acts only at a
	// boundary edge
	irq_pick_if pick_bus ();

	irq_pick picker (
		.pick_port (pick_bus)
	);

	// Source enables: six from register 0, eight from 1, six from 2
	// Reserved enable bits never reach the
	// request path and read back as zero.
	assign enable_vec = {st.ext_enable_reg2[5:0], st.ext_enable_reg1, st.irq_enable_reg0[5:0]};
	// Global enable masks every source
	assign global_on = st.irq_enable_reg0[`GLOBAL_IRQ_BIT];

	// Per-source live request: pending, enabled and globally enabled
	// Masked flags stay set and wait
	for (genvar g = 0; g < `NUM_SOURCES; g++) begin : g_req
		assign live_req[g] = st.pending[g] & enable_vec[g] & global_on;
	end

	// After a multi-cycle instruction the live requests are seen; after a single-cycle
	// one the poll taken a cycle earlier is used, so a late enable clear can slip by
	assign cand = multi_cycle_i ? live_req : st.req_delayed;
	assign cand_hi = cand & st.level;
	// High level requests are picked first, lowest index inside a level
	// One level at a time goes to the picker;
	// preemption is decided at the boundary.
	assign pick_bus.req = (|cand_hi) ? cand_hi : (cand & ~st.level);

	// Next state. Later updates win on a shared
	// field: writes, then arithmetic, then stack
	// and pointer steps, then vectoring. So a
	// hardware flag update beats a status write.
	always_comb begin
		// Scratch values
		logic [8:0]  wide;
		logic [4:0]  nib;
		logic [15:0] prod;
		logic [7:0]  a;
		logic [7:0]  opnd;
		logic        cin;
		logic        hit_level;
		logic [4:0]  order;
		logic [19:0] hw_clear;
		logic [19:0] sw_pend;
		wide = 9'h000;
		nib = 5'h00;
		prod = 16'h0000;
		a = st.primary_arith_register;
		opnd = arith_operand_i;
		cin = 1'b0;
		hit_level = 1'b0;
		order = 5'h00;
		hw_clear = 20'h00000;
		sw_pend = st.pending;
		next_st = st;
		next_st.read_data = 8'h00;
		next_st.stack_write = 1'b0;
		next_st.stack_read = 1'b0;
		next_st.vector_take = 1'b0;

		// Register writes from the core's special-register port
		// Reserved bits are masked so they read
		// back as zero, their future default.
		if (sfr_write_i) begin
			case (sfr_addr_i)
				`ADDR_STACK_POINTER:  next_st.stack_pointer = sfr_wdata_i;
				`ADDR_DATA_PTR_LOW:   next_st.data_pointer_low = sfr_wdata_i;
				`ADDR_DATA_PTR_HIGH:  next_st.data_pointer_high = sfr_wdata_i;
				`ADDR_STATUS_WORD:    next_st.program_status_word = sfr_wdata_i & `PSW_WRITE_MASK;
				`ADDR_PRIMARY_ARITH:  next_st.primary_arith_register = sfr_wdata_i;
				`ADDR_SECOND_OPERAND: next_st.second_operand_register = sfr_wdata_i;
				`ADDR_IRQ_ENABLE0:    next_st.irq_enable_reg0 = sfr_wdata_i & `ENABLE0_MASK;
				`ADDR_EXT_ENABLE1:    next_st.ext_enable_reg1 = sfr_wdata_i;
				`ADDR_EXT_ENABLE2:    next_st.ext_enable_reg2 = sfr_wdata_i & `ENABLE2_MASK;
				`ADDR_IRQ_LEVEL0:     next_st.level[5:0] = sfr_wdata_i[5:0];
				`ADDR_IRQ_LEVEL1:     next_st.level[13:6] = sfr_wdata_i;
				`ADDR_IRQ_LEVEL2:     next_st.level[19:14] = sfr_wdata_i[5:0];
				// Writing a one raises the flag as an event would; zero clears it
				`ADDR_IRQ_PENDING0:   sw_pend[7:0] = sfr_wdata_i;
				`ADDR_IRQ_PENDING1:   sw_pend[15:8] = sfr_wdata_i;
				`ADDR_IRQ_PENDING2:   sw_pend[19:16] = sfr_wdata_i[3:0];
				default: ;
			endcase
		end

		// Register reads; unmapped addresses read as zero
		// Parity comes from the live accumulator,
		// so it can never go stale.
		if (sfr_read_i) begin
			case (sfr_addr_i)
				`ADDR_STACK_POINTER:  next_st.read_data = st.stack_pointer;
				`ADDR_DATA_PTR_LOW:   next_st.read_data = st.data_pointer_low;
				`ADDR_DATA_PTR_HIGH:  next_st.read_data = st.data_pointer_high;
				`ADDR_STATUS_WORD:    next_st.read_data = {st.program_status_word[7:1],
					^st.primary_arith_register};
				`ADDR_PRIMARY_ARITH:  next_st.read_data = st.primary_arith_register;
				`ADDR_SECOND_OPERAND: next_st.read_data = st.second_operand_register;
				`ADDR_IRQ_ENABLE0:    next_st.read_data = st.irq_enable_reg0;
				`ADDR_EXT_ENABLE1:    next_st.read_data = st.ext_enable_reg1;
				`ADDR_EXT_ENABLE2:    next_st.read_data = st.ext_enable_reg2;
				`ADDR_IRQ_LEVEL0:     next_st.read_data = {2'b00, st.level[5:0]};
				`ADDR_IRQ_LEVEL1:     next_st.read_data = st.level[13:6];
				`ADDR_IRQ_LEVEL2:     next_st.read_data = {2'b00, st.level[19:14]};
				`ADDR_IRQ_PENDING0:   next_st.read_data = st.pending[7:0];
				`ADDR_IRQ_PENDING1:   next_st.read_data = st.pending[15:8];
				`ADDR_IRQ_PENDING2:   next_st.read_data = {4'h0, st.pending[19:16]};
				default:              next_st.read_data = 8'h00;
			endcase
		end

		// Arithmetic results and flags; these override a same-cycle status write
		// Nine- and five-bit sums give the carry out
		// of bits 7 and 3; for subtraction the same
		// bit is the borrow.
		if (arith_valid_i) begin
			cin = (arith_op_i == ARITH_ADDC || arith_op_i == ARITH_SUBB) ?
				st.program_status_word[`PSW_CARRY] : 1'b0;
			case (arith_op_i)
				ARITH_ADD, ARITH_ADDC: begin
					wide = {1'b0, a} + {1'b0, opnd} + {8'h00, cin};
					nib = {1'b0, a[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
					next_st.primary_arith_register = wide[7:0];
					next_st.program_status_word[`PSW_CARRY] = wide[8];
					next_st.program_status_word[`PSW_HALF_CARRY] = nib[4];
					next_st.program_status_word[`PSW_SIGNED_WRAP] =
						(a[7] == opnd[7]) && (wide[7] != a[7]);
				end
				ARITH_SUBB: begin
					wide = {1'b0, a} - {1'b0, opnd} - {8'h00, cin};
					nib = {1'b0, a[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cin};
					next_st.primary_arith_register = wide[7:0];
					next_st.program_status_word[`PSW_CARRY] = wide[8];
					next_st.program_status_word[`PSW_HALF_CARRY] = nib[4];
					next_st.program_status_word[`PSW_SIGNED_WRAP] =
						(a[7] != opnd[7]) && (wide[7] != a[7]);
				end
				ARITH_MUL: begin
					// A non-zero high byte means overflow
					prod = {8'h00, a} * {8'h00, st.second_operand_register};
					next_st.primary_arith_register = prod[7:0];
					next_st.second_operand_register = prod[15:8];
					next_st.program_status_word[`PSW_CARRY] = 1'b0;
					next_st.program_status_word[`PSW_HALF_CARRY] = 1'b0;
					next_st.program_status_word[`PSW_SIGNED_WRAP] = |prod[15:8];
				end
				ARITH_DIV: begin
					// A zero divisor leaves both accumulators as they were
					if (st.second_operand_register != 8'h00) begin
						next_st.primary_arith_register = a / st.second_operand_register;
						next_st.second_operand_register = a % st.second_operand_register;
					end
					next_st.program_status_word[`PSW_CARRY] = 1'b0;
					next_st.program_status_word[`PSW_HALF_CARRY] = 1'b0;
					next_st.program_status_word[`PSW_SIGNED_WRAP] =
						(st.second_operand_register == 8'h00);
				end
				default: ;
			endcase
		end

		// Stack: pointer moves up before the byte lands, so it names the top entry
		// Push wins over pop. The pointer wraps as
		// an 8-bit count; keeping the stack in its
		// area is left to software.
		if (push_i) begin
			next_st.stack_pointer = next_st.stack_pointer + 8'h01;
			next_st.stack_addr = next_st.stack_pointer;
			next_st.stack_data = push_data_i;
			next_st.stack_write = 1'b1;
		end else if (pop_i) begin
			next_st.stack_addr = st.stack_pointer;
			next_st.stack_read = 1'b1;
			next_st.stack_pointer = next_st.stack_pointer - 8'h01;
		end

		// Data pointer increment carries across both bytes
		// A same-cycle byte write is stepped too
		if (data_ptr_inc_i) begin
			{next_st.data_pointer_high, next_st.data_pointer_low} =
				{next_st.data_pointer_high, next_st.data_pointer_low} + 16'h0001;
		end

		// Request poll held one cycle for the single-cycle boundary case
		// Lets a request posted while the global
		// enable clears win after a 1-cycle instr
		next_st.req_delayed = live_req;

		// Vector at an instruction boundary; never on the boundary ending a return,
		// so one further instruction always runs before re-entry.
		// Active bits track the two nesting levels;
		// an entry without its return blocks every
		// later low-level entry.
		if (boundary_i && return_from_irq_i) begin
			// Return ends the high routine first
			if (st.active_hi) begin
				next_st.active_hi = 1'b0;
			end else begin
				next_st.active_lo = 1'b0;
			end
		end else if (boundary_i && pick_bus.hit) begin
			hit_level = st.level[pick_bus.index];
			// A high request preempts a low routine; nothing preempts a high one
			if (!st.active_hi && (hit_level || !st.active_lo)) begin
				// Slot 19 is unused, so the top source
				// moves up one; eight bytes per slot
				order = (pick_bus.index >= `RESERVED_SLOT) ? pick_bus.index + 5'h01 :
					pick_bus.index;
				next_st.vector_take = 1'b1;
				next_st.vector_addr = `VECTOR_BASE + (16'(order) << `VECTOR_SHIFT);
				if (hit_level) begin
					next_st.active_hi = 1'b1;
				end else begin
					next_st.active_lo = 1'b1;
				end
				// Flags outside the mask stay set until
				// the routine clears them
				hw_clear = `HW_CLEAR_MASK & (20'h00001 << pick_bus.index);
			end
		end

		// Events set pending flags whatever the enables; a set beats any clear
		// A held event keeps setting its flag and
		// re-enters its routine after the return
		next_st.pending = (sw_pend & ~hw_clear) | irq_event_i;

		// Registered views that follow the state they describe
		// Taken from next_st so they line up with
		// the register they mirror
		next_st.bank_base = {3'b000,
			next_st.program_status_word[`PSW_BANK_HI:`PSW_BANK_LO], 3'b000};
		next_st.parity = ^next_st.primary_arith_register;
	end

	// State register; synchronous reset
	// Whole struct cleared, so every flag and
	// pulse is quiet; the stack pointer is 0x07
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st <= '0;
			st.stack_pointer <= `RESET_STACK_POINTER;
			st.data_pointer_low <= `RESET_BYTE;
			st.data_pointer_high <= `RESET_BYTE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs taken straight from the state register
	// No combinational path reaches a pin; the
	// pulses come one cycle after their request
	assign sfr_rdata_o = st.read_data;
	assign stack_write_o = st.stack_write;
	assign stack_read_o = st.stack_read;
	assign stack_addr_o = st.stack_addr;
	assign stack_data_o = st.stack_data;
	assign data_pointer16_o = {st.data_pointer_high, st.data_pointer_low};
	assign bank_base_o = st.bank_base;
	assign parity_o = st.parity;
	assign vector_take_o = st.vector_take;
	assign vector_addr_o = st.vector_addr;
	assign global_irq_enable_o = st.irq_enable_reg0[`GLOBAL_IRQ_BIT];
endmodule

// [testbench/core_status_monitor.sv]
/* Port-level checker for the core status block.
   Assumes it is bound onto the top module and that everything runs on clk_i. */
module core_status_monitor (
	input logic        clk_i,
	input logic        reset_i,
	input logic        push_i,
	input logic [7:0]  push_data_i,
	input logic        pop_i,
	input logic        stack_write_o,
	input logic        stack_read_o,
	input logic [7:0]  stack_addr_o,
	input logic [7:0]  stack_data_o,
	input logic [7:0]  bank_base_o,
	input logic        boundary_i,
	input logic        return_from_irq_i,
	input logic        vector_take_o,
	input logic [15:0] vector_addr_o,
	input logic        global_irq_enable_o
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// Stack side effects one cycle after the request
	push_store_a: assert property (
		push_i |=> stack_write_o && stack_data_o == $past(push_data_i))
		else $error("push byte not stored");
	push_incr_a: assert property (
		push_i ##1 push_i |=> stack_addr_o == $past(stack_addr_o) + 8'h01)
		else $error("push did not advance the top");
	pop_read_a: assert property (
		pop_i && !push_i |=> stack_read_o && !stack_write_o)
		else $error("pop did not read the top");
	bank_shape_a: assert property (
		bank_base_o[2:0] == 3'h0 && bank_base_o[7:5] == 3'h0)
		else $error("bank base off the bank grid");

	// Vectoring only at a plain instruction end, as a single pulse
	take_boundary_a: assert property (
		vector_take_o |-> $past(boundary_i) && !$past(return_from_irq_i))
		else $error("vector taken away from a plain boundary");
	take_pulse_a: assert property (
		vector_take_o |=> !vector_take_o)
		else $error("vector pulse too long");
	vector_slot_a: assert property (
		vector_take_o |-> vector_addr_o[2:0] == 3'h3 && vector_addr_o <= 16'h00a3
			&& vector_addr_o != 16'h009b)
		else $error("vector outside the slot table");
	// Allows the late take right after the global enable drops
	take_global_a: assert property (
		vector_take_o |-> $past(global_irq_enable_o) || $past(global_irq_enable_o, 2))
		else $error("vector taken while globally masked");

	cover property (vector_take_o);
	cover property (push_i ##1 push_i);
	cover property (pop_i);
	cover property (vector_take_o && !global_irq_enable_o);
endmodule

bind core_status_regs_and_irq_entry core_status_monitor mon_u (
	.clk_i(clk_i), .reset_i(reset_i), .push_i(push_i), .push_data_i(push_data_i),
	.pop_i(pop_i), .stack_write_o(stack_write_o), .stack_read_o(stack_read_o),
	.stack_addr_o(stack_addr_o), .stack_data_o(stack_data_o), .bank_base_o(bank_base_o),
	.boundary_i(boundary_i), .return_from_irq_i(return_from_irq_i), .vector_take_o(vector_take_o),
	.vector_addr_o(vector_addr_o), .global_irq_enable_o(global_irq_enable_o)
);

// [testbench/irq_source_model.sv]
/* Model of the peripherals and pins that raise interrupt events.
   Assumes the bench asks for events on clk_i; each ask becomes a one-cycle event. */
module irq_source_model (
	input  logic        clk_i,
	input  logic [19:0] fire_i,
	output logic [19:0] irq_event_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Events are pulses only, so the block must hold the flag itself
	initial irq_event_o = 20'h00000;
	always @(posedge clk_i) begin
		irq_event_o <= #1 fire_i;
	end
endmodule

// [testbench/core_status_regs_and_irq_entry_test.sv]
/* Directed bench for the core status block: register bus, stack, flags, vectoring.
   Assumes the design package, design files, checker and source model are compiled first. */
module core_status_regs_and_irq_entry_test;
	timeunit 1ns;
	timeprecision 1ns;
	import core_status_pkg::*;

	logic         clk_i = 1'b0, reset_i = 1'b1;
	logic         sfr_write_i = 1'b0, sfr_read_i = 1'b0, arith_valid_i = 1'b0;
	logic         push_i = 1'b0, pop_i = 1'b0, data_ptr_inc_i = 1'b0;
	logic         boundary_i = 1'b0, multi_cycle_i = 1'b0, return_from_irq_i = 1'b0;
	logic [7:0]   sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
	logic [7:0]   arith_operand_i = 8'h00, push_data_i = 8'h00;
	arith_op_type arith_op_i = ARITH_ADD;
	logic [19:0]  fire = 20'h00000, irq_event_i;
	logic [7:0]   sfr_rdata_o, stack_addr_o, stack_data_o, bank_base_o;
	logic         stack_write_o, stack_read_o, parity_o, vector_take_o, global_irq_enable_o;
	logic [15:0]  data_pointer16_o, vector_addr_o;
	logic [7:0]   reg_addr [6] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0};
	int           err_count = 0, samples_checked = 0;

	always #50 clk_i = ~clk_i;

	core_status_regs_and_irq_entry dut_u (.clk_i, .reset_i, .sfr_addr_i, .sfr_write_i,
		.sfr_read_i, .sfr_wdata_i, .sfr_rdata_o, .arith_valid_i, .arith_op_i,
		.arith_operand_i, .push_i, .push_data_i, .pop_i, .data_ptr_inc_i, .stack_write_o,
		.stack_read_o, .stack_addr_o, .stack_data_o, .data_pointer16_o, .bank_base_o,
		.parity_o, .irq_event_i, .boundary_i, .multi_cycle_i, .return_from_irq_i, .vector_take_o,
		.vector_addr_o, .global_irq_enable_o);
	irq_source_model model_u (.clk_i(clk_i), .fire_i(fire), .irq_event_o(irq_event_i));

	// Inputs always move 1 ns after the edge so sampling never races
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask
	task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_write_i = 1'b1;
		tick();
		sfr_write_i = 1'b0;
		tick();
	endtask
	// Read data stands one cycle only, so it is compared right after the edge
	task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr_i = a;
		sfr_read_i = 1'b1;
		tick();
		sfr_read_i = 1'b0;
		check(sfr_rdata_o, exp, "read data");
		tick();
	endtask
	// One instruction end; a take must show exactly one cycle later
	task automatic end_instr(input logic rt, input logic tk, input logic [15:0] va);
		boundary_i = 1'b1;
		multi_cycle_i = 1'b1;
		return_from_irq_i = rt;
		tick();
		boundary_i = 1'b0;
		multi_cycle_i = 1'b0;
		return_from_irq_i = 1'b0;
		check(vector_take_o, tk, "take");
		if (tk)
			check(vector_addr_o, va, "vector");
		tick();
	endtask
	// Clears the global enable, then ends an instruction at the very next edge
	task automatic clear_global_end(input logic mc, input logic tk);
		sfr_addr_i = 8'ha8;
		sfr_wdata_i = 8'h04;
		sfr_write_i = 1'b1;
		tick();
		sfr_write_i = 1'b0;
		boundary_i = 1'b1;
		multi_cycle_i = mc;
		tick();
		boundary_i = 1'b0;
		multi_cycle_i = 1'b0;
		check(vector_take_o, tk, "late take");
		check(global_irq_enable_o, 1'b0, "global enable");
		tick();
	endtask
	task automatic fire_src(input logic [19:0] v);
		fire = v;
		tick();
		fire = 20'h00000;
		repeat (2) tick();
	endtask
	task automatic run_arith(input logic [7:0] pin, a, bv, input arith_op_type op,
		input logic [7:0] opnd, want_acc, want_psw);
		sfr_wr(8'he0, a);
		sfr_wr(8'hf0, bv);
		sfr_wr(8'hd0, pin);
		arith_op_i = op;
		arith_operand_i = opnd;
		arith_valid_i = 1'b1;
		tick();
		arith_valid_i = 1'b0;
		tick();
		sfr_rd(8'he0, want_acc);
		sfr_rd(8'hd0, want_psw);
	endtask
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard: well beyond the directed sequence length
	initial begin
		#2000000;
		err_count++;
		report_and_stop();
	end

	initial begin
		repeat (10) tick();
		reset_i = 1'b0;
		foreach (reg_addr[i])
			sfr_rd(reg_addr[i], (i == 0) ? 8'h07 : 8'h00);
		done("reset values");
		sfr_wr(8'h81, 8'h5a);
		sfr_rd(8'h81, 8'h5a);
		push_data_i = 8'haa;
		push_i = 1'b1;
		tick();
		check({stack_write_o, stack_addr_o, stack_data_o}, 17'h15baa, "push");
		push_data_i = 8'hbb;
		tick();
		check({stack_write_o, stack_addr_o, stack_data_o}, 17'h15cbb, "push");
		push_i = 1'b0;
		pop_i = 1'b1;
		tick();
		pop_i = 1'b0;
		check({stack_read_o, stack_addr_o}, 9'h15c, "pop");
		tick();
		sfr_rd(8'h81, 8'h5b);
		done("stack");
		sfr_wr(8'h82, 8'hff);
		sfr_wr(8'h83, 8'h12);
		check(data_pointer16_o, 16'h12ff, "data pointer");
		data_ptr_inc_i = 1'b1;
		tick();
		data_ptr_inc_i = 1'b0;
		tick();
		check(data_pointer16_o, 16'h1300, "data pointer");
		done("data pointer");
		for (int i = 0; i < 4; i++) begin
			sfr_wr(8'hd0, {3'h1, i[1:0], 3'h3});
			check(bank_base_o, {3'h0, i[1:0], 3'h0}, "bank");
			sfr_rd(8'hd0, {3'h1, i[1:0], 3'h2});
		end
		done("status word");
		run_arith(8'h20, 8'h7f, 8'h00, ARITH_ADD, 8'h01, 8'h80, 8'h65);
		run_arith(8'h20, 8'hff, 8'h00, ARITH_ADD, 8'h01, 8'h00, 8'he0);
		run_arith(8'ha0, 8'h10, 8'h00, ARITH_ADDC, 8'h05, 8'h16, 8'h21);
		run_arith(8'h20, 8'h00, 8'h00, ARITH_SUBB, 8'h01, 8'hff, 8'he0);
		run_arith(8'h20, 8'h80, 8'h00, ARITH_SUBB, 8'h01, 8'h7f, 8'h65);
		run_arith(8'he4, 8'h10, 8'h10, ARITH_MUL, 8'h00, 8'h00, 8'h24);
		run_arith(8'h24, 8'hff, 8'h01, ARITH_MUL, 8'h00, 8'hff, 8'h20);
		run_arith(8'h20, 8'h55, 8'h00, ARITH_DIV, 8'h00, 8'h55, 8'h24);
		run_arith(8'h24, 8'h09, 8'h02, ARITH_DIV, 8'h00, 8'h04, 8'h21);
		done("arithmetic flags");
		sfr_wr(8'ha8, 8'h04);
		fire_src(20'h00004);
		end_instr(1'b0, 1'b0, 16'h0000);
		sfr_rd(8'hc4, 8'h04);
		sfr_wr(8'ha8, 8'h84);
		check(global_irq_enable_o, 1'b1, "global enable");
		end_instr(1'b0, 1'b1, 16'h0013);
		sfr_rd(8'hc4, 8'h00);
		end_instr(1'b1, 1'b0, 16'h0000);
		done("masking and entry");
		sfr_wr(8'ha8, 8'ha1);
		fire_src(20'h00021);
		end_instr(1'b0, 1'b1, 16'h0003);
		end_instr(1'b1, 1'b0, 16'h0000);
		end_instr(1'b0, 1'b1, 16'h002b);
		sfr_wr(8'hc4, 8'h00);
		end_instr(1'b1, 1'b0, 16'h0000);
		end_instr(1'b0, 1'b0, 16'h0000);
		done("fixed order");
		sfr_wr(8'he6, 8'h04);
		sfr_wr(8'hc5, 8'h01);
		end_instr(1'b0, 1'b1, 16'h0043);
		end_instr(1'b1, 1'b0, 16'h0000);
		end_instr(1'b0, 1'b1, 16'h0043);
		sfr_wr(8'he7, 8'h20);
		sfr_wr(8'hf7, 8'h20);
		fire_src(20'h80000);
		end_instr(1'b0, 1'b1, 16'h00a3);
		sfr_wr(8'hc5, 8'h00);
		sfr_wr(8'hc6, 8'h00);
		end_instr(1'b1, 1'b0, 16'h0000);
		end_instr(1'b1, 1'b0, 16'h0000);
		end_instr(1'b0, 1'b0, 16'h0000);
		done("re-entry and levels");
		sfr_wr(8'ha8, 8'h84);
		sfr_wr(8'hc4, 8'h04);
		clear_global_end(1'b0, 1'b1);
		check(vector_addr_o, 16'h0013, "vector");
		end_instr(1'b1, 1'b0, 16'h0000);
		sfr_wr(8'ha8, 8'h84);
		sfr_wr(8'hc4, 8'h04);
		clear_global_end(1'b1, 1'b0);
		sfr_rd(8'hc4, 8'h04);
		done("global enable clear");
		report_and_stop();
	end
endmodule
